// ---- logic/porst_timer.sv ----
// Functional notes
// - reset pad always a power-on source
// - software selects one extra GPIO source
// - delay factor is seven bits, max 0x7F
// - expiry after factor times 4096 slow periods
// - counter advances on slow oscillator rising edges
// - asserted source forces slow oscillator on
// - pad uses default trim, GPIO programmed
// - short pad pulse hardware reset, long power-on
// - reset pad is active high
// - selected pin stays a normal GPIO
// - pin number zero disables GPIO source
// - polarity bit zero low, one high
// - counter clears when source releases early
// - overlapping sources share one running count
// - pad expires once, must release first
// - resets clear pin; power-on restores delay
// - both resets request full cold start
//
// Local design decisions: the APB slave port and the register offsets.
`include "porst_defines.svh"

module porst_timer
    import porst_pkg::*;
#(
    parameter int unsigned TICKS_PER_FACTOR = `PORST_TICKS_PER_FACTOR
) (
    input  wire logic                       pclk,            // system clock, 50 MHz
    input  wire logic                       presetn,         // async reset, low
    input  wire logic                       psel,            // apb select
    input  wire logic                       penable,         // apb enable
    input  wire logic                       pwrite,          // apb direction
    input  wire logic [`PORST_ADDR_W-1:0]   paddr,           // apb byte address
    input  wire logic [31:0]                pwdata,          // apb write data
    output logic      [31:0]                prdata,          // apb read data
    output logic                            pready,          // apb ready
    output logic                            pslverr,         // apb error
    input  wire logic                       reset_pad,       // reset pad, high
    input  wire logic [`PORST_NUM_GPIO-1:0] gpio_in,         // gpio pin levels
    input  wire logic                       slow_rc_clk,     // slow oscillator
    input  wire logic                       hw_rst_done,     // hw reset seen
    input  wire logic                       sw_rst_done,     // sw reset seen
    output logic                            por_req,         // power-on pulse
    output logic                            hwr_req,         // hw reset pulse
    output logic                            cold_start_req,  // cold start pulse
    output logic                            slow_rc_osc_en,  // oscillator on
    output logic                            slow_rc_trim_dflt // default trim
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic gpio_pick(input logic [`PORST_NUM_GPIO-1:0] lvl,
                                       input logic [`PORST_PIN_W-1:0]    pin,
                                       input logic                       pol);
        logic raw;
        raw = 1'b0;
        if (pin != `PORST_PIN_W'(0) && 32'(pin) < `PORST_NUM_GPIO) begin
            raw = lvl[pin];
        end
        return (pin != `PORST_PIN_W'(0)) && (pol ? raw : !raw);
    endfunction

    function automatic logic is_mapped(input logic [`PORST_ADDR_W-1:0] a);
        return (a == `PORST_SRC_OFS) || (a == `PORST_DELAY_OFS) ||
               (a == `PORST_STATUS_OFS) || (a == `PORST_COUNT_OFS) ||
               (a == `PORST_OSCCTL_OFS);
    endfunction

    function automatic logic is_ro(input logic [`PORST_ADDR_W-1:0] a);
        return (a == `PORST_STATUS_OFS) || (a == `PORST_COUNT_OFS);
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic                       pad_s;
    logic [`PORST_NUM_GPIO-1:0] gpio_s;
    logic                       rc_s;

    porst_sync #(.W(`PORST_NUM_GPIO + 2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({reset_pad, gpio_in, slow_rc_clk}),
        .dout    ({pad_s, gpio_s, rc_s})
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    porst_state_type               st_ff;
    porst_state_type               nxt_st;
    logic [`PORST_PIN_W-1:0]       pin_ff;
    logic [`PORST_PIN_W-1:0]       nxt_pin;
    logic                          pol_ff;
    logic                          nxt_pol;
    logic [`PORST_DELAY_W-1:0]     delay_ff;
    logic [`PORST_DELAY_W-1:0]     nxt_delay;
    logic                          oscen_ff;
    logic                          nxt_oscen;
    logic                          pad_seen_ff;
    logic                          nxt_pad_seen;
    logic                          rc_prev_ff;
    logic                          por_ff;
    logic                          nxt_por;
    logic                          hwr_ff;
    logic                          nxt_hwr;
    logic                          cold_ff;
    logic                          last_por_ff;
    logic                          nxt_last_por;
    logic                          last_hwr_ff;
    logic                          nxt_last_hwr;
    logic                          osc_on_ff;
    logic                          trim_dflt_ff;
    logic [31:0]                   prdata_ff;
    logic [31:0]                   nxt_prdata;

    logic                          gpio_act;
    logic                          any_src;
    logic                          tick;
    logic                          run;
    logic                          expired;
    logic [`PORST_CNT_W-1:0]       count;
    logic                          wr_acc;
    logic                          rd_setup;

    assign gpio_act = gpio_pick(gpio_s, pin_ff, pol_ff);
    assign any_src  = pad_s || gpio_act;
    assign tick     = rc_s && !rc_prev_ff;
    assign run      = (st_ff == PORST_ST_COUNT) && any_src;

    // ----------------------------------------------------------------
    // delay counter
    // ----------------------------------------------------------------
    porst_delay_cnt #(.TICKS(TICKS_PER_FACTOR)) u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .tick    (tick),
        .factor  (delay_ff),
        .count   (count),
        .expired (expired)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_pad_seen = pad_seen_ff;
        nxt_por      = 1'b0;
        nxt_hwr      = 1'b0;
        case (st_ff)
            PORST_ST_IDLE: begin
                nxt_pad_seen = pad_s;
                if (any_src) begin
                    nxt_st = PORST_ST_COUNT;
                end
            end
            PORST_ST_COUNT: begin
                nxt_pad_seen = pad_seen_ff || pad_s;
                if (expired) begin
                    nxt_por = 1'b1;
                    nxt_st  = pad_s ? PORST_ST_HOLD : PORST_ST_IDLE;
                end else if (!any_src) begin
                    nxt_hwr = pad_seen_ff;
                    nxt_st  = PORST_ST_IDLE;
                end
            end
            PORST_ST_HOLD: begin
                if (!pad_s) begin
                    nxt_st = PORST_ST_IDLE;
                end
            end
            default: begin
                nxt_st = PORST_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers and apb
    // ----------------------------------------------------------------
    assign wr_acc   = psel && penable && pwrite && is_mapped(paddr) && !is_ro(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        nxt_pin      = pin_ff;
        nxt_pol      = pol_ff;
        nxt_delay    = delay_ff;
        nxt_oscen    = oscen_ff;
        nxt_last_por = last_por_ff || nxt_por;
        nxt_last_hwr = last_hwr_ff || nxt_hwr;
        nxt_prdata   = prdata_ff;
        if (wr_acc && paddr == `PORST_SRC_OFS) begin
            nxt_pin = pwdata[`PORST_PIN_LSB +: `PORST_PIN_W];
            nxt_pol = pwdata[`PORST_POL_BIT];
        end
        if (wr_acc && paddr == `PORST_DELAY_OFS) begin
            nxt_delay = pwdata[`PORST_DELAY_W-1:0];
        end
        if (wr_acc && paddr == `PORST_OSCCTL_OFS) begin
            nxt_oscen = pwdata[`PORST_OSCEN_BIT];
        end
        if (nxt_por || nxt_hwr || hw_rst_done || sw_rst_done) begin
            nxt_pin = `PORST_PIN_RST;
        end
        if (nxt_por) begin
            nxt_delay = `PORST_DELAY_RST;
        end
        if (rd_setup) begin
            nxt_prdata = 32'h0000_0000;
            case (paddr)
                `PORST_SRC_OFS: begin
                    nxt_prdata[`PORST_PIN_LSB +: `PORST_PIN_W] = pin_ff;
                    nxt_prdata[`PORST_POL_BIT] = pol_ff;
                end
                `PORST_DELAY_OFS: begin
                    nxt_prdata[`PORST_DELAY_W-1:0] = delay_ff;
                end
                `PORST_STATUS_OFS: begin
                    nxt_prdata[5:0] = {last_hwr_ff, last_por_ff, osc_on_ff,
                                       st_ff == PORST_ST_HOLD, gpio_act, pad_s};
                end
                `PORST_COUNT_OFS: begin
                    nxt_prdata[`PORST_CNT_W-1:0] = count;
                end
                `PORST_OSCCTL_OFS: begin
                    nxt_prdata[`PORST_OSCEN_BIT] = oscen_ff;
                end
                default: begin
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff        <= PORST_ST_IDLE;
            pin_ff       <= `PORST_PIN_RST;
            pol_ff       <= `PORST_POL_RST;
            delay_ff     <= `PORST_DELAY_RST;
            oscen_ff     <= `PORST_OSCEN_RST;
            pad_seen_ff  <= 1'b0;
            rc_prev_ff   <= 1'b0;
            por_ff       <= 1'b0;
            hwr_ff       <= 1'b0;
            cold_ff      <= 1'b0;
            last_por_ff  <= 1'b0;
            last_hwr_ff  <= 1'b0;
            osc_on_ff    <= `PORST_OSCEN_RST;
            trim_dflt_ff <= 1'b0;
            prdata_ff    <= 32'h0000_0000;
        end else begin
            st_ff        <= nxt_st;
            pin_ff       <= nxt_pin;
            pol_ff       <= nxt_pol;
            delay_ff     <= nxt_delay;
            oscen_ff     <= nxt_oscen;
            pad_seen_ff  <= nxt_pad_seen;
            rc_prev_ff   <= rc_s;
            por_ff       <= nxt_por;
            hwr_ff       <= nxt_hwr;
            cold_ff      <= nxt_por || nxt_hwr;
            last_por_ff  <= nxt_last_por;
            last_hwr_ff  <= nxt_last_hwr;
            osc_on_ff    <= oscen_ff || any_src;
            trim_dflt_ff <= pad_s;
            prdata_ff    <= nxt_prdata;
        end
    end

    // gpio pins are only observed here, never driven
    assign por_req           = por_ff;
    assign hwr_req           = hwr_ff;
    assign cold_start_req    = cold_ff;
    assign slow_rc_osc_en    = osc_on_ff;
    assign slow_rc_trim_dflt = trim_dflt_ff;
    assign prdata            = prdata_ff;
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && (!is_mapped(paddr) || (pwrite && is_ro(paddr)));

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_POR_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == PORST_ST_COUNT) && expired |=> por_ff && !hwr_ff)
        else $error("expiry did not issue power-on");

    AST_ONE_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        por_ff || hwr_ff |=> !por_ff && !hwr_ff)
        else $error("more than one reset per assertion");

    AST_PAD_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == PORST_ST_HOLD) && pad_s |=> !por_ff && (st_ff == PORST_ST_HOLD))
        else $error("held pad reloaded the timer");

    AST_OSC_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
        any_src |=> osc_on_ff)
        else $error("oscillator not forced on by source");

    AST_TRIM: assert property (@(posedge pclk) disable iff (!presetn)
        pad_s |=> trim_dflt_ff)
        else $error("default trim not chosen for pad");

    AST_PIN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        hw_rst_done || sw_rst_done || nxt_por || nxt_hwr |=> pin_ff == `PORST_PIN_RST)
        else $error("pin selection survived a reset");

    AST_DELAY_RESTORE: assert property (@(posedge pclk) disable iff (!presetn)
        por_ff |-> delay_ff == `PORST_DELAY_RST)
        else $error("delay factor not restored");

    AST_GPIO_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        pin_ff == `PORST_PIN_W'(0) |-> !gpio_act)
        else $error("gpio source active with pin zero");

    AST_COLD: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(por_ff) || $rose(hwr_ff) |-> cold_ff)
        else $error("reset without cold start");

    AST_HWR_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
        hwr_ff |-> $past(st_ff == PORST_ST_COUNT) && !$past(expired) && !$past(pad_s))
        else $error("hardware reset without short pad pulse");

    AST_PAD_START: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == PORST_ST_IDLE) && pad_s |=> st_ff == PORST_ST_COUNT)
        else $error("pad did not start the timer");

endmodule // porst_timer

// ---- logic/porst_defines.svh ----
`ifndef PORST_DEFINES_SVH
`define PORST_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PORST_ADDR_W          12
`define PORST_SRC_OFS         12'h000
`define PORST_DELAY_OFS       12'h004
`define PORST_STATUS_OFS      12'h008
`define PORST_COUNT_OFS       12'h00C
`define PORST_OSCCTL_OFS      12'h010

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define PORST_PIN_LSB         0
`define PORST_PIN_W           4
`define PORST_POL_BIT         8
`define PORST_DELAY_W         7
`define PORST_OSCEN_BIT       0
`define PORST_NUM_GPIO        12
`define PORST_CNT_W           19

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PORST_PIN_RST         4'h0
`define PORST_POL_RST         1'h0
`define PORST_DELAY_RST       7'h18
`define PORST_DELAY_MAX       7'h7F
`define PORST_OSCEN_RST       1'h1

// ----------------------------------------------------------------
// timing: slow oscillator periods per unit of delay factor
// ----------------------------------------------------------------
`define PORST_TICKS_PER_FACTOR 4096

`endif

// ---- logic/porst_pkg.sv ----
package porst_pkg;

    // ----------------------------------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PORST_ST_IDLE  = 3'h1,
        PORST_ST_COUNT = 3'h2,
        PORST_ST_HOLD  = 3'h4
    } porst_state_type;

endpackage

// ---- logic/porst_sync.sv ----
module porst_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,     // system clock
    input  wire logic         presetn,  // async reset, low
    input  wire logic [W-1:0] din,      // asynchronous level
    output logic      [W-1:0] dout      // synchronised level
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;

endmodule // porst_sync

// ---- logic/porst_delay_cnt.sv ----
`include "porst_defines.svh"

module porst_delay_cnt #(
    parameter int unsigned TICKS = `PORST_TICKS_PER_FACTOR
) (
    input  wire logic                      pclk,     // system clock
    input  wire logic                      presetn,  // async reset, low
    input  wire logic                      run,      // a source is held
    input  wire logic                      tick,     // slow oscillator edge
    input  wire logic [`PORST_DELAY_W-1:0] factor,   // delay factor
    output logic      [`PORST_CNT_W-1:0]   count,    // elapsed periods
    output logic                           expired   // delay reached
);

    logic [`PORST_CNT_W-1:0] cnt_ff;
    logic [`PORST_CNT_W-1:0] nxt_cnt;
    logic [`PORST_CNT_W-1:0] target;

    assign target  = `PORST_CNT_W'(factor * TICKS);
    assign expired = run && (cnt_ff >= target);
    assign count   = cnt_ff;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (!run) begin
            nxt_cnt = '0;
        end else if (tick && !expired) begin
            nxt_cnt = cnt_ff + `PORST_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    AST_CNT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> cnt_ff == '0) else $error("delay count not cleared on release");

endmodule // porst_delay_cnt

// ---- dv/porst_far_side.sv ----
module porst_far_side #(
    parameter real SLOW_HALF_NS = 97.0
) (
    input  wire logic        pclk,         // system clock
    input  wire logic        osc_en,       // oscillator enable from block
    output logic             reset_pad,    // reset pad level
    output logic [11:0]      gpio_in,      // gpio pin levels
    output logic             slow_rc_clk   // slow oscillator output
);
    timeunit 1ns;
    timeprecision 1ps;

    // pad has a pull-down, gpio lines idle high
    initial begin
        reset_pad = 1'b0;
        gpio_in = 12'hFFF;
        slow_rc_clk = 1'b0;
    end

    // oscillator runs only while enabled, phase unrelated to pclk
    always begin
        if (osc_en === 1'b1) begin
            #(SLOW_HALF_NS) slow_rc_clk = ~slow_rc_clk;
        end else begin
            slow_rc_clk = 1'b0;
            @(osc_en);
        end
    end

    // high requests a reset; low is the released level
    task automatic drive_pad(input logic v);
        @(posedge pclk);
        reset_pad <= v;
    endtask

    task automatic drive_gpio(input int idx, input logic v);
        @(posedge pclk);
        gpio_in[idx] <= v;
    endtask

    task automatic drive_all(input logic [11:0] v);
        @(posedge pclk);
        gpio_in <= v;
    endtask
endmodule // porst_far_side

// ---- dv/porst_timer_tb.sv ----
`include "porst_defines.svh"

module porst_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TPF = 4;
    localparam int SLOW_PER = 194;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        hw_rst_done, sw_rst_done, reset_pad, slow_rc_clk;
    logic        por_req, hwr_req, cold_start_req, slow_rc_osc_en, slow_rc_trim_dflt;
    logic [11:0] paddr, gpio_in;
    logic [31:0] pwdata, prdata, rd;
    int          n_fail, num_checks, n_por, n_hwr, n_cold, p0, h0, c0, cyc;

    porst_timer #(.TICKS_PER_FACTOR(TPF)) u_porst_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pad(reset_pad), .gpio_in(gpio_in),
        .slow_rc_clk(slow_rc_clk), .hw_rst_done(hw_rst_done), .sw_rst_done(sw_rst_done),
        .por_req(por_req), .hwr_req(hwr_req), .cold_start_req(cold_start_req),
        .slow_rc_osc_en(slow_rc_osc_en), .slow_rc_trim_dflt(slow_rc_trim_dflt));
    porst_far_side u_porst_far_side (.pclk(pclk), .osc_en(slow_rc_osc_en), .reset_pad(reset_pad),
        .gpio_in(gpio_in), .slow_rc_clk(slow_rc_clk));

    always #10 pclk = ~pclk;

    // ----------------------------------------------------------------
    // reset request pulse counters
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        n_por += int'(por_req === 1'b1);
        n_hwr += int'(hwr_req === 1'b1);
        n_cold += int'(cold_start_req === 1'b1);
    end

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, waits for pready; only the watchdog ends a hung wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        check_word("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check_word(what, exp, rd);
    endtask

    task automatic snap;
        p0 = n_por;
        h0 = n_hwr;
        c0 = n_cold;
    endtask

    task automatic chk_pulses(input string what, input int ep, input int eh);
        check_word({what, " por"}, ep, n_por - p0);
        check_word({what, " hwr"}, eh, n_hwr - h0);
        check_word({what, " cold"}, ep + eh, n_cold - c0);
    endtask

    task automatic wait_por(input int pre, input int factor);
        int b;
        int exp;
        b = n_por;
        cyc = pre;
        exp = factor * TPF * SLOW_PER / 20;
        while (n_por == b && cyc < 3000) begin
            @(posedge pclk);
            cyc++;
        end
        check_word("por time", 32'h1, {31'h0, cyc >= exp - 10 && cyc <= exp + 15});
    endtask

    task automatic pulse(input logic hw);
        hw_rst_done <= hw;
        sw_rst_done <= ~hw;
        @(posedge pclk);
        hw_rst_done <= 1'b0;
        sw_rst_done <= 1'b0;
        @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_regs;
        rd_chk("src", `PORST_SRC_OFS, 32'h0);
        rd_chk("delay", `PORST_DELAY_OFS, 32'h18);
        rd_chk("oscctl", `PORST_OSCCTL_OFS, 32'h1);
        apb(1'b0, `PORST_OSCCTL_OFS + 12'h004, 32'h0, 1'b1);
        check_word("unmapped", 32'h0, rd);
        apb(1'b1, `PORST_STATUS_OFS, 32'hFFFFFFFF, 1'b1);
        wr(`PORST_DELAY_OFS, 32'hFF);
        rd_chk("delay max", `PORST_DELAY_OFS, 32'h7F);
    endtask

    task automatic sc_ext_rst;
        wr(`PORST_SRC_OFS, 32'h5);
        pulse(1'b1);
        rd_chk("src hw", `PORST_SRC_OFS, 32'h0);
        wr(`PORST_SRC_OFS, 32'h5);
        pulse(1'b0);
        rd_chk("src sw", `PORST_SRC_OFS, 32'h0);
    endtask

    task automatic sc_pad_short;
        wr(`PORST_DELAY_OFS, 32'h2);
        snap();
        u_porst_far_side.drive_pad(1'b1);
        repeat (30) @(posedge pclk);
        check_word("trim pad", 32'h1, {31'h0, slow_rc_trim_dflt});
        u_porst_far_side.drive_pad(1'b0);
        repeat (20) @(posedge pclk);
        chk_pulses("short", 0, 1);
        rd_chk("count", `PORST_COUNT_OFS, 32'h0);
    endtask

    task automatic sc_pad_long;
        wr(`PORST_OSCCTL_OFS, 32'h0);
        repeat (20) @(posedge pclk);
        check_word("osc off", 32'h0, {31'h0, slow_rc_osc_en});
        snap();
        u_porst_far_side.drive_pad(1'b1);
        repeat (6) @(posedge pclk);
        check_word("osc forced", 32'h1, {31'h0, slow_rc_osc_en});
        wait_por(6, 2);
        repeat (200) @(posedge pclk);
        chk_pulses("long held", 1, 0);
        rd_chk("status hold", `PORST_STATUS_OFS, 32'h3D);
        u_porst_far_side.drive_pad(1'b0);
        repeat (20) @(posedge pclk);
        chk_pulses("long", 1, 0);
        rd_chk("delay dflt", `PORST_DELAY_OFS, 32'h18);
        wr(`PORST_OSCCTL_OFS, 32'h1);
    endtask

    task automatic sc_gpio(input logic pol);
        int pin;
        pin = pol ? 8 : 3;
        u_porst_far_side.drive_gpio(pin, ~pol);
        wr(`PORST_SRC_OFS, 32'(pin));
        wr(`PORST_SRC_OFS, 32'(pin) | {23'h0, pol, 8'h0});
        wr(`PORST_DELAY_OFS, 32'h1);
        repeat (20) @(posedge pclk);
        snap();
        u_porst_far_side.drive_gpio(pin, pol);
        repeat (6) @(posedge pclk);
        check_word("trim gpio", 32'h0, {31'h0, slow_rc_trim_dflt});
        wait_por(6, 1);
        chk_pulses("gpio", 1, 0);
        rd_chk("src cleared", `PORST_SRC_OFS, {23'h0, pol, 8'h0});
        u_porst_far_side.drive_gpio(pin, 1'b1);
    endtask

    task automatic sc_pin_zero;
        wr(`PORST_SRC_OFS, 32'h0);
        wr(`PORST_DELAY_OFS, 32'h1);
        snap();
        u_porst_far_side.drive_all(12'h000);
        repeat (100) @(posedge pclk);
        chk_pulses("pin zero", 0, 0);
        u_porst_far_side.drive_all(12'hFFF);
    endtask

    task automatic sc_overlap;
        u_porst_far_side.drive_gpio(2, 1'b0);
        wr(`PORST_SRC_OFS, 32'h2);
        wr(`PORST_SRC_OFS, 32'h102);
        wr(`PORST_DELAY_OFS, 32'h2);
        repeat (20) @(posedge pclk);
        snap();
        u_porst_far_side.drive_pad(1'b1);
        repeat (40) @(posedge pclk);
        u_porst_far_side.drive_gpio(2, 1'b1);
        repeat (10) @(posedge pclk);
        u_porst_far_side.drive_pad(1'b0);
        wait_por(53, 2);
        chk_pulses("overlap", 1, 0);
    endtask

    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_fail++;
        complete_run();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, hw_rst_done, sw_rst_done} = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        sc_regs();
        sc_ext_rst();
        sc_pad_short();
        sc_pad_long();
        sc_gpio(1'b0);
        sc_gpio(1'b1);
        sc_pin_zero();
        sc_overlap();
        complete_run();
    end
endmodule // porst_timer_tb
